// *** rtl/cfg_bank_pkg.sv ***
/*
  Package for the deserializer configuration register bank: offsets,
  field positions, reset values, timing constants and carrier structs.
  Assumes an APB slave with 32-bit data and 8-bit registers in the low bits.
*/
package cfg_bank_pkg;

  localparam int unsigned ADDR_WIDTH        = 8;
  localparam int unsigned REG_COUNT         = 18;

  // Printed offsets are not all multiples of four, so they are indices.
  localparam logic [4:0] IDX_SER_ADDR       = 5'h00;
  localparam logic [4:0] IDX_OWN_ADDR       = 5'h01;
  localparam logic [4:0] IDX_SPREAD_AUDIO   = 5'h02;
  localparam logic [4:0] IDX_SPREAD_CAL     = 5'h03;
  localparam logic [4:0] IDX_LINK_STATE     = 5'h04;
  localparam logic [4:0] IDX_EQ_CTRL        = 5'h05;
  localparam logic [4:0] IDX_OUT_PIN        = 5'h06;
  localparam logic [4:0] IDX_RSVD_A         = 5'h07;
  localparam logic [4:0] IDX_SYNC_FILT      = 5'h08;
  localparam logic [4:0] IDX_RSVD_B         = 5'h09;
  localparam logic [4:0] IDX_RSVD_C         = 5'h0a;
  localparam logic [4:0] IDX_RSVD_D         = 5'h0b;
  localparam logic [4:0] IDX_FAULT_THR      = 5'h0c;
  localparam logic [4:0] IDX_FAULT_CNT      = 5'h0d;
  localparam logic [4:0] IDX_PATTERN_CNT    = 5'h0e;
  localparam logic [4:0] IDX_RSVD_E         = 5'h0f;
  localparam logic [4:0] IDX_RSVD_F         = 5'h10;
  localparam logic [4:0] IDX_REV_RATE       = 5'h11;
  localparam logic [4:0] IDX_LOCK_LAST      = 5'h1f;

  // Writable masks per register; other bits hold their fixed patterns.
  localparam logic [7:0] WMASK_SER_ADDR     = 8'hfe;
  localparam logic [7:0] WMASK_OWN_ADDR     = 8'hff;
  localparam logic [7:0] WMASK_SPREAD_AUDIO = 8'hff;
  localparam logic [7:0] WMASK_SPREAD_CAL   = 8'hdf;
  localparam logic [7:0] WMASK_LINK_STATE   = 8'h7f;
  localparam logic [7:0] WMASK_EQ_CTRL      = 8'hff;
  localparam logic [7:0] WMASK_OUT_PIN      = 8'he0;
  localparam logic [7:0] WMASK_SYNC_FILT    = 8'h07;
  localparam logic [7:0] WMASK_FAULT_THR    = 8'hff;
  localparam logic [7:0] WMASK_REV_RATE     = 8'h80;

  // Reset values; pin-dependent bits are merged in at reset release.
  localparam logic [7:0] RST_SER_ADDR       = 8'h00;
  localparam logic [7:0] RST_OWN_ADDR       = 8'h08;
  localparam logic [7:0] RST_SPREAD_AUDIO   = 8'h1f;
  localparam logic [7:0] RST_SPREAD_CAL     = 8'h00;
  localparam logic [7:0] RST_LINK_STATE     = 8'h07;
  localparam logic [7:0] RST_EQ_CTRL        = 8'h29;
  localparam logic [7:0] RST_OUT_PIN        = 8'h00;
  localparam logic [7:0] RST_RSVD_A         = 8'h54;
  localparam logic [7:0] RST_SYNC_FILT      = 8'h30;
  localparam logic [7:0] RST_RSVD_B         = 8'hc8;
  localparam logic [7:0] RST_RSVD_C         = 8'h10;
  localparam logic [7:0] RST_RSVD_D         = 8'h20;
  localparam logic [7:0] RST_ZERO           = 8'h00;
  localparam logic [7:0] RST_REV_RATE       = 8'h22;

  // Field positions.
  localparam int unsigned BIT_LOCK          = 0;
  localparam int unsigned BIT_AUDIO_DIR     = 5;
  localparam int unsigned BIT_AUDIO_ON      = 4;
  localparam int unsigned BIT_ACQUIRED      = 7;
  localparam int unsigned BIT_OUT_DISABLE   = 6;
  localparam int unsigned BIT_PATTERN_ON    = 5;
  localparam int unsigned BIT_SLEEP         = 4;
  localparam int unsigned BIT_REV_LINK      = 1;
  localparam int unsigned BIT_FWD_LINK      = 0;
  localparam int unsigned BIT_BRIDGE_MODE   = 7;
  localparam int unsigned BIT_EQ_PD         = 4;
  localparam int unsigned BIT_STAGGER_OFF   = 7;
  localparam int unsigned BIT_AUTO_CLEAR    = 6;
  localparam int unsigned BIT_FWD_DISABLE   = 5;
  localparam int unsigned BIT_INPUT_LEVEL   = 4;
  localparam int unsigned BIT_REV_FAST      = 7;
  localparam logic [1:0]  RANGE_AUTO        = 2'h3;
  localparam logic [4:0]  DIVIDER_AUTO      = 5'h00;
  localparam logic [3:0]  BOOST_MAX         = 4'hb;

  // Timing at a 250 MHz clock.
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned AUTO_CLEAR_US     = 1;
  localparam int unsigned AUTO_CLEAR_CYCLES = AUTO_CLEAR_US * CLK_MHZ;
  localparam int unsigned RECAL_2_MS        = 2;
  localparam int unsigned RECAL_16_MS       = 16;
  localparam int unsigned RECAL_256_MS      = 256;
  localparam int unsigned RECAL_2_CYCLES    = RECAL_2_MS * CLK_MHZ * 1000;
  localparam int unsigned RECAL_16_CYCLES   = RECAL_16_MS * CLK_MHZ * 1000;
  localparam int unsigned RECAL_256_CYCLES  = RECAL_256_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {
    LINK_TWO_WIRE = 2'b00,
    LINK_UART     = 2'b01,
    LINK_OFF_A    = 2'b10,
    LINK_OFF_B    = 2'b11
  } local_link_kind_type;

  typedef struct packed {
    logic                local_bus_select_pin;
    logic                link_acquired;
    logic                input_pin_level;
    logic                decode_fault;
    logic                pattern_mismatch;
    logic                power_down_pin_n;
  } status_in_type;

  typedef struct packed {
    logic [6:0]          serializer_bus_address;
    logic [6:0]          deserializer_bus_address;
    logic [1:0]          spread_mode;
    logic                audio_clock_direction;
    logic                audio_channel_on;
    logic [1:0]          pixel_clock_range;
    logic [1:0]          serial_rate_range;
    logic [1:0]          spread_recal_interval;
    logic [4:0]          sawtooth_divider;
    logic                sawtooth_auto;
    logic                parallel_output_disable;
    logic                pattern_test_on;
    logic                sleep_mode;
    logic                two_wire_local;
    logic                uart_local;
    logic                reverse_ctrl_link_on;
    logic                forward_ctrl_link_on;
    logic                uart_bridge_address_mode;
    logic [1:0]          eq_highpass_cutoff;
    logic                eq_power_down;
    logic [3:0]          eq_boost_gain;
    logic                stagger_off;
    logic                input_forward_disable;
    logic [2:0]          deglitch_off;
    logic [7:0]          decode_fault_threshold;
    logic                reverse_link_rate_select;
    logic                spread_recal_strobe;
  } config_out_type;

endpackage

// *** rtl/recal_timer.sv ***
/*
  Spread modulation recalibration timer. Fires once after lock in one-shot
  mode or periodically at the selected interval while the link is held.
  Assumes a lock level synchronous to pclk and a clock enable.
*/
`timescale 1ns/1ns
module recal_timer
  import cfg_bank_pkg::*;
#(
  parameter int unsigned P2  = RECAL_2_CYCLES,
  parameter int unsigned P16 = RECAL_16_CYCLES,
  parameter int unsigned P256 = RECAL_256_CYCLES
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       link_acquired_flag,
  input  wire logic [1:0] interval,
  output logic            strobe
);

  initial begin
    if (P2 < 1 || P16 < 1 || P256 < 1 || P256 >= 2**30) begin
      $error("recal_timer: interval counts out of range");
    end
  end

  logic [29:0] count_reg;
  logic        link_acquired_flag_reg;
  logic [29:0] limit;

  always_comb begin
    unique case (interval)
      2'b01:   limit = 30'(P2 - 1);
      2'b10:   limit = 30'(P16 - 1);
      2'b11:   limit = 30'(P256 - 1);
      default: limit = 30'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_acquired_flag_reg <= 1'b0;
      count_reg  <= 30'h0;
      strobe     <= 1'b0;
    end else if (clk_en) begin
      link_acquired_flag_reg <= link_acquired_flag;
      strobe     <= 1'b0;
      if (!link_acquired_flag) begin
        count_reg <= 30'h0;
      end else if (!link_acquired_flag_reg) begin
        strobe    <= 1'b1;
        count_reg <= 30'h0;
      end else if (interval != 2'b00) begin
        if (count_reg >= limit) begin
          count_reg <= 30'h0;
          strobe    <= 1'b1;
        end else begin
          count_reg <= count_reg + 30'h1;
        end
      end
    end
  end

endmodule

// *** rtl/deserializer_config_register_bank.sv ***
/*
  APB register bank for the deserializer control and status registers at
  indices 0x00 to reverse_rate_select, byte address four times the index.
  Assumes pin levels synchronous to pclk and a single clock domain.
*/
// Function
// - While the lock bit is set, writes to indices 0x00-0x1F are ignored.
// - The lock bit stays set until reset or the power-down pin goes low.
// - Seven-bit bus addresses in bits 7:1 of 0x00/0x01, seeded by pins.
// - Audio clock direction 0 drives word select and clock, 1 accepts them.
// - Pixel clock range field selects bands or auto detect, resets to 11.
// - Serial rate range field selects bands or auto detect, resets to 11.
// - Recalibrate spread rate once or every 2, 16 or 256 ms after lock.
// - Divider value zero means automatic calibration, else manual setting.
// - Bit 7 of link_state_control reads the link-lock pin level, read only.
// - Output disable bit 1 disables outputs; seeded by enable pin.
// - Pattern test enable counts mismatches into read-only counter 0x0E.
// - Sleep bit 1 sleeps, 0 normal; seeded by mode-select pin.
// - With bus select low, kind 00 two-wire, 01 UART, else disabled.
// - Reverse send and forward receive enable bits, both reset to 1.
// - Bridge address mode 0 sends register address, 1 omits it.
// - Highpass cutoff field selects four cutoffs, resets to 01.
// - Equalizer power-down bit 0 enables, 1 disables, resets to 0.
// - Boost gain field holds twelve codes, resets to 1001; 11XX unused.
// - Auto-clear resets the fault counter 1 us after the fault asserts.
// - Input forward disable stops forwarding; bit 4 reads input level.
// - Three bits of sync_glitch_filter disable the sync and enable glitch filters.
// - Fault threshold at 0x0C and read-only fault counter at 0x0D.
// - Reverse rate bit selects 500 kbps at 0 and 1 Mbps at 1.
`timescale 1ns/1ns
module deserializer_config_register_bank
  import cfg_bank_pkg::*;
#(
  parameter int unsigned RECAL_2_PARAM   = RECAL_2_CYCLES,
  parameter int unsigned RECAL_16_PARAM  = RECAL_16_CYCLES,
  parameter int unsigned RECAL_256_PARAM = RECAL_256_CYCLES,
  parameter int unsigned CLEAR_DELAY     = AUTO_CLEAR_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clk_en,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [2:0]            address_pins,
  input  wire logic                  enable_pin,
  input  wire logic                  mode_select_pin,
  input  wire status_in_type         status_in,
  output config_out_type             config_out
);

  initial begin
    if (CLEAR_DELAY < 1 || CLEAR_DELAY >= 2**16) begin
      $error("register bank: clear delay out of range");
    end
  end

  logic [7:0]  regs_reg [REG_COUNT];
  logic [7:0]  wmask    [REG_COUNT];
  // Reset values are constants, so the reset branch loads no logic values.
  localparam logic [7:0] RST_TABLE [REG_COUNT] = '{
    RST_SER_ADDR,
    RST_OWN_ADDR,
    RST_SPREAD_AUDIO,
    RST_SPREAD_CAL,
    RST_LINK_STATE,
    RST_EQ_CTRL,
    RST_OUT_PIN,
    RST_RSVD_A,
    RST_SYNC_FILT,
    RST_RSVD_B,
    RST_RSVD_C,
    RST_RSVD_D,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_REV_RATE
  };
  logic        lock_reg;
  logic        straps_done_reg;
  logic        fault_d_reg;
  logic        clear_pending_reg;
  logic [15:0] clear_count_reg;
  logic [7:0]  fault_cnt_reg;
  logic [7:0]  pattern_cnt_reg;
  logic        recal_strobe;
  logic [4:0]  index;
  logic        addr_ok;
  logic        setup;
  logic        wr_take;
  logic [7:0]  rd_byte;
  logic [7:0]  reg04;
  logic [7:0]  reg06;

  assign index   = paddr[6:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[7] == 1'b0)
                   && (index < 5'(REG_COUNT));
  assign setup   = psel && !penable;
  // Writes land at the access edge where the master sees pready, and are
  // blocked over the whole IDX_LOCK_LAST range while locked, not only mapped ones.
  assign wr_take = psel && penable && pready && pwrite && addr_ok
                   && pstrb[0] && !(lock_reg && index <= IDX_LOCK_LAST);

  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      wmask[i]  = 8'h00;
    end
    wmask[IDX_SER_ADDR]      = WMASK_SER_ADDR;
    wmask[IDX_OWN_ADDR]      = WMASK_OWN_ADDR;
    wmask[IDX_SPREAD_AUDIO]  = WMASK_SPREAD_AUDIO;
    wmask[IDX_SPREAD_CAL]    = WMASK_SPREAD_CAL;
    wmask[IDX_LINK_STATE]    = WMASK_LINK_STATE;
    wmask[IDX_EQ_CTRL]       = WMASK_EQ_CTRL;
    wmask[IDX_OUT_PIN]       = WMASK_OUT_PIN;
    wmask[IDX_SYNC_FILT]     = WMASK_SYNC_FILT;
    wmask[IDX_FAULT_THR]     = WMASK_FAULT_THR;
    wmask[IDX_REV_RATE]      = WMASK_REV_RATE;
  end

  // Storage per register; the lock bit and counters live apart.
  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : gen_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          regs_reg[g] <= RST_TABLE[g];
        end else if (clk_en) begin
          if (!straps_done_reg && g == IDX_SER_ADDR) begin
            regs_reg[g] <= {2'b00, 2'b00, address_pins[2:1], 1'b0,
                            1'b0};
          end else if (!straps_done_reg && g == IDX_OWN_ADDR) begin
            regs_reg[g] <= {2'b00, 2'b01, address_pins[2:0],
                            1'b0};
          end else if (!straps_done_reg && g == IDX_LINK_STATE) begin
            regs_reg[g] <= {1'b0, !enable_pin, 1'b0, mode_select_pin,
                            RST_TABLE[g][3:0]};
          end else if (wr_take && index == 5'(g)) begin
            regs_reg[g] <= (regs_reg[g] & ~wmask[g])
                           | (pwdata[7:0] & wmask[g]);
          end
        end
      end
    end
  endgenerate

  // Straps are caught on the first enabled clock after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      straps_done_reg <= 1'b0;
    end else if (clk_en) begin
      straps_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
    end else if (clk_en) begin
      if (!status_in.power_down_pin_n) begin
        lock_reg <= 1'b0;
      end else if (wr_take && index == IDX_OWN_ADDR
                   && pwdata[BIT_LOCK]) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // A fault edge arms a 1 us delay; a new edge restarts it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_d_reg       <= 1'b0;
      clear_pending_reg <= 1'b0;
      clear_count_reg   <= 16'h0;
    end else if (clk_en) begin
      fault_d_reg <= status_in.decode_fault;
      if (status_in.decode_fault && !fault_d_reg
          && regs_reg[IDX_OUT_PIN][BIT_AUTO_CLEAR]) begin
        clear_pending_reg <= 1'b1;
        clear_count_reg   <= 16'(CLEAR_DELAY - 1);
      end else if (clear_pending_reg) begin
        if (clear_count_reg == 16'h0) begin
          clear_pending_reg <= 1'b0;
        end else begin
          clear_count_reg <= clear_count_reg - 16'h1;
        end
      end
    end
  end

  // Counters saturate; a new fault in the clear cycle still counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_cnt_reg <= 8'h00;
    end else if (clk_en) begin
      if (status_in.decode_fault && !fault_d_reg) begin
        fault_cnt_reg <= (clear_pending_reg && clear_count_reg == 16'h0)
                         ? 8'h01 : (fault_cnt_reg == 8'hff ? 8'hff
                         : fault_cnt_reg + 8'h01);
      end else if (clear_pending_reg && clear_count_reg == 16'h0) begin
        fault_cnt_reg <= 8'h00;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pattern_cnt_reg <= 8'h00;
    end else if (clk_en) begin
      if (regs_reg[IDX_LINK_STATE][BIT_PATTERN_ON]
          && status_in.pattern_mismatch && pattern_cnt_reg != 8'hff) begin
        pattern_cnt_reg <= pattern_cnt_reg + 8'h01;
      end
    end
  end

  recal_timer #(
    .P2   (RECAL_2_PARAM),
    .P16  (RECAL_16_PARAM),
    .P256 (RECAL_256_PARAM)
  ) u_recal (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .link_acquired_flag   (status_in.link_acquired),
    .interval (regs_reg[IDX_SPREAD_CAL][7:6]),
    .strobe   (recal_strobe)
  );

  assign reg04 = {status_in.link_acquired,
                  regs_reg[IDX_LINK_STATE][6:0]};
  assign reg06 = {regs_reg[IDX_OUT_PIN][7:5], status_in.input_pin_level,
                  4'h0};

  always_comb begin
    rd_byte = regs_reg[index < 5'(REG_COUNT) ? index : 5'h0];
    if (index == IDX_OWN_ADDR) begin
      rd_byte = {regs_reg[IDX_OWN_ADDR][7:1], lock_reg};
    end else if (index == IDX_LINK_STATE) begin
      rd_byte = reg04;
    end else if (index == IDX_OUT_PIN) begin
      rd_byte = reg06;
    end else if (index == IDX_FAULT_CNT) begin
      rd_byte = fault_cnt_reg;
    end else if (index == IDX_PATTERN_CNT) begin
      rd_byte = pattern_cnt_reg;
    end
  end

  // No wait state: the answer is registered in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup && !addr_ok;
      if (setup && !pwrite) begin
        prdata <= addr_ok ? {24'h0, rd_byte} : 32'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_out <= '0;
    end else if (clk_en) begin
      config_out.serializer_bus_address   <= regs_reg[IDX_SER_ADDR][7:1];
      config_out.deserializer_bus_address <= regs_reg[IDX_OWN_ADDR][7:1];
      config_out.spread_mode              <= regs_reg[IDX_SPREAD_AUDIO][7:6];
      config_out.audio_clock_direction    <=
        regs_reg[IDX_SPREAD_AUDIO][BIT_AUDIO_DIR];
      config_out.audio_channel_on <= regs_reg[IDX_SPREAD_AUDIO][BIT_AUDIO_ON];
      config_out.pixel_clock_range <= regs_reg[IDX_SPREAD_AUDIO][3:2];
      config_out.serial_rate_range <= regs_reg[IDX_SPREAD_AUDIO][1:0];
      config_out.spread_recal_interval <= regs_reg[IDX_SPREAD_CAL][7:6];
      config_out.sawtooth_divider <= regs_reg[IDX_SPREAD_CAL][4:0];
      config_out.sawtooth_auto <=
        regs_reg[IDX_SPREAD_CAL][4:0] == DIVIDER_AUTO;
      config_out.parallel_output_disable <=
        regs_reg[IDX_LINK_STATE][BIT_OUT_DISABLE];
      config_out.pattern_test_on <= regs_reg[IDX_LINK_STATE][BIT_PATTERN_ON];
      config_out.sleep_mode <= regs_reg[IDX_LINK_STATE][BIT_SLEEP];
      config_out.two_wire_local <= !status_in.local_bus_select_pin
        && regs_reg[IDX_LINK_STATE][3:2] == LINK_TWO_WIRE;
      config_out.uart_local <= !status_in.local_bus_select_pin
        && regs_reg[IDX_LINK_STATE][3:2] == LINK_UART;
      config_out.reverse_ctrl_link_on <=
        regs_reg[IDX_LINK_STATE][BIT_REV_LINK];
      config_out.forward_ctrl_link_on <=
        regs_reg[IDX_LINK_STATE][BIT_FWD_LINK];
      config_out.uart_bridge_address_mode <=
        regs_reg[IDX_EQ_CTRL][BIT_BRIDGE_MODE];
      config_out.eq_highpass_cutoff <= regs_reg[IDX_EQ_CTRL][6:5];
      config_out.eq_power_down <= regs_reg[IDX_EQ_CTRL][BIT_EQ_PD];
      // Unused boost codes are clamped so the analog never sees them.
      config_out.eq_boost_gain <= (regs_reg[IDX_EQ_CTRL][3:0] > BOOST_MAX)
        ? BOOST_MAX : regs_reg[IDX_EQ_CTRL][3:0];
      config_out.stagger_off <= regs_reg[IDX_OUT_PIN][BIT_STAGGER_OFF];
      config_out.input_forward_disable <=
        regs_reg[IDX_OUT_PIN][BIT_FWD_DISABLE];
      config_out.deglitch_off <= regs_reg[IDX_SYNC_FILT][2:0];
      config_out.decode_fault_threshold <= regs_reg[IDX_FAULT_THR];
      config_out.reverse_link_rate_select <=
        regs_reg[IDX_REV_RATE][BIT_REV_FAST];
      config_out.spread_recal_strobe <= recal_strobe;
    end
  end

endmodule

// *** bench/cfg_bank_properties.sv ***
/* Protocol and field checks on the register bank ports.
   Assumes one clock domain and bind to every bank instance. */
`timescale 1ns/1ns
module cfg_bank_properties
  import cfg_bank_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            clk_en,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire config_out_type  config_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable && clk_en;
  answer_next_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  boost_clamp_a: assert property (config_out.eq_boost_gain <= BOOST_MAX)
    else $error("boost code out of range");
  unmapped_err_a: assert property (setup && paddr[6:2] > 5'h11 |=> pslverr)
    else $error("unmapped access not refused");
  rsvd_read_a: assert property (setup && !pwrite && paddr == 8'h1c
    |=> prdata[7:0] == RST_RSVD_A) else $error("reserved pattern wrong");
  filt_upper_a: assert property (setup && !pwrite && paddr == 8'h20
    |=> prdata[7:3] == 5'h06) else $error("filter upper bits wrong");
endmodule
bind deserializer_config_register_bank cfg_bank_properties u_props (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .config_out(config_out));

// *** bench/deserializer_config_register_bank_tb.sv ***
/* Self-checking bench for the register bank over APB.
   Assumes short timing parameters and straps fixed through the run. */
`timescale 1ns/1ns
module deserializer_config_register_bank_tb;
  import cfg_bank_pkg::*;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0, rd;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err_seen;
  logic [2:0] address_pins = 3'h5;
  logic enable_pin = 1, mode_select_pin = 0;
  status_in_type status_in = 6'h01;
  config_out_type config_out;
  int num_errors = 0, n_checks = 0, cycles = 0, n_strobes = 0;
  logic [7:0] rst_tab [0:17] = '{8'h08, 8'h1a, 8'h1f, 8'h00, 8'h07, 8'h29,
    8'h00, 8'h54, 8'h30, 8'hc8, 8'h10, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h22};
  logic [4:0] a_idx [6] = '{5'h0c, 5'h0d, 5'h07, 5'h08, 5'h11, 5'h06};
  logic [7:0] a_wr [6] = '{8'ha5, 8'h33, 8'h00, 8'hff, 8'hff, 8'hff};
  logic [7:0] a_ex [6] = '{8'ha5, 8'h00, 8'h54, 8'h37, 8'ha2, 8'he0};
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    if (config_out.spread_recal_strobe === 1'b1) n_strobes++;
  end
  deserializer_config_register_bank #(.RECAL_2_PARAM(10), .RECAL_16_PARAM(20),
    .RECAL_256_PARAM(40), .CLEAR_DELAY(4)) i_dut (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .address_pins(address_pins), .enable_pin(enable_pin),
    .mode_select_pin(mode_select_pin), .status_in(status_in),
    .config_out(config_out));
  task automatic chk(input string name, input logic [7:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [7:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= {1'b0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    // The bench timeout ends a wait that never sees ready.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err_seen = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [4:0] idx, input logic [7:0] exp);
    xfer(0, idx, 8'h0);
    chk("read data", exp, rd);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 18; i++) begin
      rdc(i[4:0], rst_tab[i]);
    end
  endtask
  task automatic t_access;
    for (int i = 0; i < 6; i++) begin
      xfer(1, a_idx[i], a_wr[i]);
      rdc(a_idx[i], a_ex[i]);
    end
    status_in.input_pin_level <= 1;
    rdc(5'h06, 8'hf0);
    xfer(1, 5'h06, 8'h00);
    pstrb <= 4'h0;
    xfer(1, 5'h0c, 8'h11);
    pstrb <= 4'hf;
    rdc(5'h0c, 8'ha5);
    xfer(0, 5'h12, 8'h0);
    chk("error flag", 8'h01, {7'h0, err_seen});
  endtask
  task automatic t_eq;
    xfer(1, 5'h05, 8'h1a);
    xfer(1, 5'h02, 8'h3f);
    @(posedge pclk);
    chk("boost gain", 8'h0a, {4'h0, config_out.eq_boost_gain});
    chk("eq off", 8'h01, {7'h0, config_out.eq_power_down});
    chk("audio dir", 8'h01, {7'h0, config_out.audio_clock_direction});
  endtask
  task automatic t_link;
    status_in.link_acquired <= 1;
    xfer(1, 5'h04, 8'h27);
    status_in.pattern_mismatch <= 1;
    repeat (3) @(posedge pclk);
    status_in.pattern_mismatch <= 0;
    rdc(5'h0e, 8'h03);
    rdc(5'h04, 8'ha7);
    chk("recal strobes", 8'h01, n_strobes[7:0]);
    chk("uart local", 8'h01, {7'h0, config_out.uart_local});
    xfer(1, 5'h04, 8'h07);
  endtask
  task automatic t_fault;
    repeat (2) begin
      status_in.decode_fault <= 1;
      @(posedge pclk);
      status_in.decode_fault <= 0;
      @(posedge pclk);
    end
    rdc(5'h0d, 8'h02);
    xfer(1, 5'h06, 8'h40);
    status_in.decode_fault <= 1;
    repeat (20) @(posedge pclk);
    status_in.decode_fault <= 0;
    rdc(5'h0d, 8'h00);
  endtask
  task automatic t_lock;
    xfer(1, 5'h01, 8'h11);
    xfer(1, 5'h0c, 8'h3c);
    rdc(5'h0c, 8'ha5);
    xfer(1, 5'h01, 8'h10);
    rdc(5'h01, 8'h11);
    status_in.power_down_pin_n <= 0;
    repeat (2) @(posedge pclk);
    status_in.power_down_pin_n <= 1;
    @(posedge pclk);
    xfer(1, 5'h0c, 8'h3c);
    rdc(5'h0c, 8'h3c);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    t_reset;
    t_access;
    t_eq;
    t_link;
    t_fault;
    t_lock;
    summarize;
  end
endmodule
